// ===== hw/uart_receive_status.sv
`timescale 1ns/100ps
module uart_receive_status
  import uart_rx_pkg::*;
(
  input  wire logic                    clock_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    rx_line_in,
  input  wire logic [uart_rx_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic [uart_rx_pkg::REG_W-1:0]  reg_wdata_in,
  input  wire logic                    reg_write_in,
  input  wire logic                    reg_read_in,
  output logic [uart_rx_pkg::REG_W-1:0]       reg_rdata_out,
  output logic                         receiver_idle_out
);
  import uart_rx_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_STOP  = 4'b1000
  } rx_state_e;

  typedef struct packed {
    rx_state_e          phase;
    logic [15:0]        tick;
    logic [3:0]         bit_index;
    logic [DATA_W-1:0]  rx_shift_register;
    logic               parity_bad;
    logic               address_detect_enable;
    logic               overrun_error_flag;
    logic               nine_bit;
    logic               parity_en;
    logic               parity_odd;
    logic [15:0]        baud;
    logic [PTR_W-1:0]   wr_ptr;
    logic [PTR_W-1:0]   rd_ptr;
    logic [CNT_W-1:0]   count;
    logic [REG_W-1:0]   rdata;
    logic               idle;
  } top_s;

  top_s state;
  top_s next_state;
  logic [ENTRY_W-1:0] fifo_mem [FIFO_DEPTH];
  logic [ENTRY_W-1:0] head;
  logic               push;
  logic               flush;
  logic               drain_ready;
  logic [ENTRY_W-1:0] push_entry;
  logic               wr_fifo;
  logic               pop;

  uart_rx_stream_if skid_in ();
  uart_rx_stream_if skid_out ();

  function automatic logic [3:0] last_bit(input logic nine, input logic par);
    // the parity cell follows the data cells, so it adds exactly one cell
    if (par && nine) begin
      last_bit = BIT_PARITY;
    end else if (par || nine) begin
      last_bit = BIT_LAST9;
    end else begin
      last_bit = BIT_LAST8;
    end
  endfunction

  uart_rx_skid u_skid (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .flush_in (flush),
    .up       (skid_in.sink),
    .down     (skid_out.source)
  );

  assign head = fifo_mem[state.rd_ptr];
  assign skid_in.valid = push;
  assign skid_in.data = push_entry;
  assign drain_ready = (state.count != CNT_W'(FIFO_DEPTH));
  assign skid_out.ready = drain_ready;
  assign wr_fifo = skid_out.valid && drain_ready && !flush;
  assign pop = reg_read_in && (reg_addr_in == ADDR_RXDATA) && (state.count != '0);
  assign flush = reg_write_in && (reg_addr_in == ADDR_STATUS) && state.overrun_error_flag
                 && !reg_wdata_in[BIT_OVR_ERR];
  assign reg_rdata_out = state.rdata;
  assign receiver_idle_out = state.idle;

  always_comb begin
    logic sample;
    logic stop_ok;
    logic keep;
    sample = 1'b0;
    stop_ok = 1'b0;
    keep = 1'b0;
    next_state = state;
    push = 1'b0;
    push_entry = '0;
    sample = (state.tick == '0);
    if (!sample) begin
      next_state.tick = 16'(state.tick - ONE16);
    end
    case (state.phase)
      ST_IDLE: begin
        if (!rx_line_in) begin
          next_state.phase = ST_START;
          next_state.tick = {1'b0, state.baud[15:1]};
        end
      end
      ST_START: begin
        if (sample) begin
          next_state.tick = state.baud;
          next_state.bit_index = '0;
          next_state.parity_bad = state.parity_odd;
          next_state.rx_shift_register = '0;
          next_state.phase = rx_line_in ? ST_IDLE : ST_DATA;
        end
      end
      ST_DATA: begin
        if (sample) begin
          next_state.tick = state.baud;
          next_state.parity_bad = state.parity_bad ^ rx_line_in;
          if (state.bit_index < (state.nine_bit ? BIT_LAST9 : BIT_LAST8)) begin
            next_state.rx_shift_register[state.bit_index] = rx_line_in;
          end
          next_state.bit_index = 4'(state.bit_index + 4'h1);
          if (state.bit_index == 4'(last_bit(state.nine_bit, state.parity_en) - 4'h1)) begin
            next_state.phase = ST_STOP;
          end
        end
      end
      ST_STOP: begin
        if (sample) begin
          stop_ok = rx_line_in;
          next_state.phase = ST_IDLE;
          // address mode drops data characters whose ninth bit is clear
          keep = !(state.address_detect_enable && state.nine_bit) // R01
                 || state.rx_shift_register[DATA_W-1];
          push = keep;
          push_entry[ENTRY_PAR_ERR] = state.parity_en && state.parity_bad;
          push_entry[ENTRY_FRM_ERR] = !stop_ok;
          push_entry[DATA_W-1:0] = state.rx_shift_register;
          if (keep && !skid_in.ready) begin
            next_state.overrun_error_flag = 1'b1; // R05
          end
        end
      end
      default: next_state.phase = ST_IDLE;
    endcase
    next_state.idle = (next_state.phase == ST_IDLE); // R02
    if (wr_fifo) begin
      next_state.wr_ptr = PTR_W'(state.wr_ptr + 1'b1);
    end
    if (pop) begin
      next_state.rd_ptr = PTR_W'(state.rd_ptr + 1'b1); // R08
    end
    next_state.count = CNT_W'(state.count + {2'b00, wr_fifo} - {2'b00, pop});
    if (reg_write_in) begin
      case (reg_addr_in)
        ADDR_STATUS: begin
          next_state.address_detect_enable = reg_wdata_in[BIT_ADDR_DET];
          if (!reg_wdata_in[BIT_OVR_ERR] && !next_state.overrun_error_flag) begin
            next_state.overrun_error_flag = 1'b0;
          end else if (!reg_wdata_in[BIT_OVR_ERR] && !(push && !skid_in.ready)) begin
            next_state.overrun_error_flag = 1'b0; // R05
          end
        end
        ADDR_CONFIG: begin
          next_state.nine_bit = reg_wdata_in[BIT_NINE];
          next_state.parity_en = reg_wdata_in[BIT_PAR_EN];
          next_state.parity_odd = reg_wdata_in[BIT_PAR_ODD];
        end
        ADDR_BAUD: next_state.baud = reg_wdata_in;
        default: ;
      endcase
    end
    if (flush) begin
      next_state.rd_ptr = '0; // R06
      next_state.wr_ptr = '0;
      next_state.count = '0;
      next_state.phase = ST_IDLE;
      next_state.rx_shift_register = '0;
      next_state.bit_index = '0;
      next_state.idle = 1'b1;
    end
    next_state.rdata = '0;
    if (reg_read_in) begin
      case (reg_addr_in)
        ADDR_STATUS: begin
          next_state.rdata[BIT_ADDR_DET] = state.address_detect_enable;
          next_state.rdata[BIT_IDLE] = state.idle; // R02
          next_state.rdata[BIT_PAR_ERR] = (state.count != '0) && head[ENTRY_PAR_ERR]; // R03
          next_state.rdata[BIT_FRM_ERR] = (state.count != '0) && head[ENTRY_FRM_ERR]; // R04
          next_state.rdata[BIT_OVR_ERR] = state.overrun_error_flag;
          next_state.rdata[BIT_AVAIL] = (state.count != '0); // R07
        end
        ADDR_RXDATA: next_state.rdata = REG_W'(head[DATA_W-1:0]);
        ADDR_CONFIG: begin
          next_state.rdata[BIT_NINE] = state.nine_bit;
          next_state.rdata[BIT_PAR_EN] = state.parity_en;
          next_state.rdata[BIT_PAR_ODD] = state.parity_odd;
        end
        ADDR_BAUD: next_state.rdata = state.baud;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state <= '{phase: ST_IDLE, baud: BAUD_RESET, idle: 1'b1, default: '0};
    end else begin
      state <= next_state;
    end
    if (wr_fifo) begin
      fifo_mem[state.wr_ptr] <= skid_out.data;
    end
  end

  sequence stop_sample;
    state.phase == ST_STOP && state.tick == '0;
  endsequence

  sequence push_blocked;
    push && !skid_in.ready;
  endsequence

  AST_IDLE_FLAG: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R02
    (state.phase == ST_IDLE) |-> state.idle)
    else $error("idle flag low while receiver idle");
  AST_OVR_HOLD: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R05
    (state.overrun_error_flag && !(reg_write_in && reg_addr_in == ADDR_STATUS))
    |=> state.overrun_error_flag)
    else $error("overrun flag dropped without a clear");
  AST_OVR_SET: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R05
    stop_sample ##0 push_blocked |=> state.overrun_error_flag)
    else $error("overrun flag not set on a lost character");
  // a lost character in the clearing cycle keeps the flag set, so that case is let through
  AST_FLUSH: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R06
    flush |=> (state.count == '0) && state.idle
              && (!state.overrun_error_flag || $past(push && !skid_in.ready)))
    else $error("overrun clear did not empty receiver");
  AST_AVAIL: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R07
    (reg_read_in && reg_addr_in == ADDR_STATUS)
    |=> state.rdata[BIT_AVAIL] == ($past(state.count) != '0))
    else $error("data available flag wrong");
  AST_PAR_ERR: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R03
    (reg_read_in && reg_addr_in == ADDR_STATUS && state.count == '0)
    |=> !state.rdata[BIT_PAR_ERR])
    else $error("parity flag set with empty buffer");
  AST_FRM_ERR: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R04
    (reg_read_in && reg_addr_in == ADDR_STATUS)
    |=> state.rdata[BIT_FRM_ERR] == ($past(state.count != '0) && $past(head[ENTRY_FRM_ERR])))
    else $error("framing flag does not match head");
  AST_POP: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R08
    (pop && !flush) |=> state.rd_ptr == PTR_W'($past(state.rd_ptr) + 1'b1))
    else $error("head did not advance on read");
  AST_ADDR: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R01
    stop_sample ##0 (state.address_detect_enable && state.nine_bit
     && !state.rx_shift_register[DATA_W-1]) |-> !push)
    else $error("data character kept in address mode");
endmodule

// ===== hw/uart_rx_pkg.sv
// How it works
// [R01] address-detect enable at bit 5 only acts in 9-bit character mode
// [R02] receiver idle flag at bit 4 is one when idle, zero while receiving
// [R03] parity error flag at bit 3 describes the character at FIFO head
// [R04] framing error flag at bit 2 describes the character at FIFO head
// [R05] overrun flag at bit 1 set on overflow; software may only clear it
// [R06] clearing overrun one to zero empties buffer and resets shift register
// [R07] data available flag at bit 0 is one while any character remains
// [R08] error flags follow the FIFO head each time it advances
package uart_rx_pkg;
  localparam int DATA_W = 9;
  localparam int ENTRY_W = DATA_W + 2;
  localparam int FIFO_DEPTH = 4;
  localparam int PTR_W = 2;
  localparam int CNT_W = 3;
  localparam int REG_W = 16;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RXDATA = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_BAUD = 4'h3;
  localparam int BIT_ADDR_DET = 5;
  localparam int BIT_IDLE = 4;
  localparam int BIT_PAR_ERR = 3;
  localparam int BIT_FRM_ERR = 2;
  localparam int BIT_OVR_ERR = 1;
  localparam int BIT_AVAIL = 0;
  localparam int BIT_NINE = 0;
  localparam int BIT_PAR_EN = 1;
  localparam int BIT_PAR_ODD = 2;
  localparam int ENTRY_PAR_ERR = DATA_W + 1;
  localparam int ENTRY_FRM_ERR = DATA_W;
  localparam logic [15:0] BAUD_RESET = 16'h0043;
  localparam logic [3:0] BIT_LAST8 = 4'h8;
  localparam logic [3:0] BIT_LAST9 = 4'h9;
  localparam logic [3:0] BIT_PARITY = 4'hA;
  localparam logic [15:0] ONE16 = 16'h0001;
endpackage

// ===== hw/uart_rx_skid.sv
`timescale 1ns/100ps
module uart_rx_skid
  import uart_rx_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic       flush_in,
  uart_rx_stream_if.sink  up,
  uart_rx_stream_if.source down
);
  typedef struct packed {
    logic [1:0]         count;
    logic [ENTRY_W-1:0] slot0;
    logic [ENTRY_W-1:0] slot1;
  } skid_s;
  skid_s state;
  skid_s next_state;
  logic  take;
  logic  give;

  assign up.ready = (state.count != 2'h2);
  assign down.valid = (state.count != 2'h0);
  assign down.data = state.slot0;
  assign take = up.valid && up.ready;
  assign give = down.valid && down.ready;

  always_comb begin
    next_state = state;
    if (give) begin
      next_state.slot0 = state.slot1;
    end
    if (take) begin
      if (state.count == 2'h0 || (state.count == 2'h1 && give)) begin
        next_state.slot0 = up.data;
      end else begin
        next_state.slot1 = up.data;
      end
    end
    next_state.count = 2'(state.count + {1'b0, take} - {1'b0, give});
    if (flush_in) begin
      next_state.count = 2'h0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule

// ===== hw/uart_rx_stream_if.sv
`timescale 1ns/100ps
interface uart_rx_stream_if;
  import uart_rx_pkg::*;
  logic               valid;
  logic               ready;
  logic [ENTRY_W-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// ===== tb/uart_receive_status_bench.sv
`timescale 1ns/100ps
module uart_receive_status_bench;
  import uart_rx_pkg::*;
  logic              clock_in = 1'b0;
  logic              rst_n_in = 1'b0;
  logic              rx_line;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [REG_W-1:0]  reg_wdata = '0;
  logic              reg_write = 1'b0;
  logic              reg_read = 1'b0;
  logic [REG_W-1:0]  reg_rdata;
  logic              receiver_idle;
  int                n_fail = 0;
  int                checks = 0;

  always #4 clock_in = ~clock_in;

  uart_tx_model #(.BIT_CLKS(4)) uart_tx_model_i (
    .clock_in   (clock_in),
    .rx_line_out(rx_line)
  );

  uart_receive_status uart_receive_status_i (
    .clock_in         (clock_in),
    .rst_n_in         (rst_n_in),
    .rx_line_in       (rx_line),
    .reg_addr_in      (reg_addr),
    .reg_wdata_in     (reg_wdata),
    .reg_write_in     (reg_write),
    .reg_read_in      (reg_read),
    .reg_rdata_out    (reg_rdata),
    .receiver_idle_out(receiver_idle)
  );

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clock_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock_in);
    reg_write <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge clock_in);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock_in);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // read one register and compare the whole word, upper bits included
  task automatic rc(input logic [ADDR_W-1:0] a, input string what, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    check(what, d, exp);
  endtask

  task automatic send8(input logic [7:0] d);
    uart_tx_model_i.send({1'b0, d}, 8, 1'b0, 1'b0, 1'b1);
  endtask

  initial begin
    #400000;
    n_fail++;
    close_out();
  end

  initial begin
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rc(ADDR_STATUS, "status reset", 16'h0010);
    rc(ADDR_BAUD, "baud reset", BAUD_RESET);
    rc(4'hF, "unmapped", 16'h0000);
    wr(ADDR_BAUD, 16'h0003);
    fork
      send8(8'h55);
      begin
        repeat (20) @(posedge clock_in);
        check("idle busy", {15'h0, receiver_idle}, 16'h0000);
      end
    join
    rc(ADDR_STATUS, "status avail", 16'h0011);
    rc(ADDR_RXDATA, "data 55", 16'h0055);
    rc(ADDR_STATUS, "status empty", 16'h0010);
    uart_tx_model_i.send(9'h00F, 8, 1'b0, 1'b0, 1'b0);
    send8(8'h33);
    rc(ADDR_STATUS, "status framing", 16'h0015);
    rc(ADDR_RXDATA, "data 0f", 16'h000F);
    rc(ADDR_STATUS, "framing follows head", 16'h0011);
    rc(ADDR_RXDATA, "data 33", 16'h0033);
    wr(ADDR_CONFIG, 16'h0002);
    uart_tx_model_i.send(9'h003, 8, 1'b1, 1'b1, 1'b1);
    uart_tx_model_i.send(9'h003, 8, 1'b1, 1'b0, 1'b1);
    rc(ADDR_STATUS, "status parity", 16'h0019);
    rc(ADDR_RXDATA, "data 03 bad", 16'h0003);
    rc(ADDR_STATUS, "parity follows head", 16'h0011);
    rc(ADDR_RXDATA, "data 03 good", 16'h0003);
    // odd parity: a good character first, then one with the wrong parity cell
    wr(ADDR_CONFIG, 16'h0006);
    uart_tx_model_i.send(9'h003, 8, 1'b1, 1'b1, 1'b1);
    uart_tx_model_i.send(9'h003, 8, 1'b1, 1'b0, 1'b1);
    rc(ADDR_STATUS, "odd parity good", 16'h0011);
    rc(ADDR_RXDATA, "data 03 odd", 16'h0003);
    rc(ADDR_STATUS, "odd parity bad", 16'h0019);
    rc(ADDR_RXDATA, "data 03 odd bad", 16'h0003);
    wr(ADDR_CONFIG, 16'h0000);
    wr(ADDR_STATUS, 16'h0002);
    rc(ADDR_STATUS, "overrun not settable", 16'h0010);
    // six places in all, so the seventh character overflows
    for (int i = 0; i < 7; i++) begin
      send8(8'h40 + i[7:0]);
    end
    rc(ADDR_STATUS, "status overrun", 16'h0013);
    rc(ADDR_STATUS, "overrun holds", 16'h0013);
    rc(ADDR_RXDATA, "oldest kept", 16'h0040);
    rc(ADDR_STATUS, "overrun after read", 16'h0013);
    wr(ADDR_STATUS, 16'h0000);
    rc(ADDR_STATUS, "flushed", 16'h0010);
    wr(ADDR_CONFIG, 16'h0001);
    wr(ADDR_STATUS, 16'h0020);
    uart_tx_model_i.send(9'h0AA, 9, 1'b0, 1'b0, 1'b1);
    uart_tx_model_i.send(9'h1AA, 9, 1'b0, 1'b0, 1'b1);
    rc(ADDR_STATUS, "addr detect", 16'h0031);
    rc(ADDR_RXDATA, "data 1aa", 16'h01AA);
    rc(ADDR_STATUS, "address char only", 16'h0030);
    wr(ADDR_CONFIG, 16'h0000);
    send8(8'h5A);
    rc(ADDR_STATUS, "enable ignored 8 bit", 16'h0031);
    rc(ADDR_RXDATA, "data 5a", 16'h005A);
    close_out();
  end
endmodule

// ===== tb/uart_tx_model.sv
`timescale 1ns/100ps
module uart_tx_model #(
  parameter int BIT_CLKS = 4
) (
  input  wire logic clock_in,
  output logic      rx_line_out
);
  // the line rests high between frames, as a real transmitter leaves it
  initial rx_line_out = 1'b1;

  task automatic wait_bit();
    repeat (BIT_CLKS) @(posedge clock_in);
  endtask

  // par_on adds a parity bit of value par_bit; stop low makes a framing fault
  task automatic send(input logic [8:0] d, input int nbits, input logic par_on,
                      input logic par_bit, input logic stop);
    @(posedge clock_in);
    rx_line_out <= 1'b0;
    wait_bit();
    for (int i = 0; i < nbits; i++) begin
      rx_line_out <= d[i];
      wait_bit();
    end
    if (par_on) begin
      rx_line_out <= par_bit;
      wait_bit();
    end
    rx_line_out <= stop;
    wait_bit();
    rx_line_out <= 1'b1;
    wait_bit();
    wait_bit();
  endtask
endmodule
